// ==== design/isp_flash_command_unit.sv ====
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "isp_flash_regs.svh"
module isp_flash_command_unit
  import isp_flash_pkg::*;
#(
  parameter int ADDR_W = 10
)
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  // wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [ADDR_W-1:0]   adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic [31:0]              dat_o,
  output logic                     ack_o,
  // cpu side
  input  wire logic                codeInLoader,
  input  wire logic                codeExternal,
  output logic                     cpuHold,
  // flash array
  output logic                     flashReq,
  output isp_flash_pkg::flash_op_t flashOp,
  output logic [17:0]              flashAddr,
  output logic [7:0]               flashWdata,
  input  wire logic [7:0]          flashRdata,
  input  wire logic                flashDone,
  output logic                     oscEnable,
  // interrupt
  output logic                     irq
);

  if (ADDR_W < 10)
  begin : g_chk
    $error("ADDR_W must be at least 10");
  end

  // bus decode
  logic       ack_q;
  logic       busReq;
  logic       busWr;
  logic       busRd;
  logic       lane0;
  logic [7:0] idx;
  logic [7:0] wByte;

  assign busReq = cyc_i && stb_i && !ack_q;
  assign lane0  = sel_i[0];
  assign busWr  = busReq && we_i && lane0;
  assign busRd  = busReq && !we_i;
  assign idx    = adr_i[9:2];
  assign wByte  = dat_i[7:0];

  logic hitTrig;
  logic hitAlo;
  logic hitAhi;
  logic hitData;
  logic hitCmd;
  logic hitCtl;
  logic hitKey;
  logic hitStat;
  logic hitMask;
  logic hitAny;

  assign hitTrig = idx == `IDX_TRIGGER;
  assign hitAlo  = idx == `IDX_ADDR_LOW;
  assign hitAhi  = idx == `IDX_ADDR_HIGH;
  assign hitData = idx == `IDX_DATA;
  assign hitCmd  = idx == `IDX_COMMAND;
  assign hitCtl  = idx == `IDX_CHIP_CTL;
  assign hitKey  = idx == `IDX_KEY;
  assign hitStat = idx == `IDX_IRQ_STAT;
  assign hitMask = idx == `IDX_IRQ_MASK;
  assign hitAny  = hitTrig | hitAlo | hitAhi | hitData | hitCmd
                 | hitCtl | hitKey | hitStat | hitMask;

  // registers
  logic [7:0] addrLow_q;
  logic [7:0] addrHigh_q;
  logic [7:0] data_q;
  logic [7:0] command_q;
  logic       progEn_q;
  logic       loaderUpd_q;
  logic       fault_q;
  logic [1:0] irqStat_q;
  logic [1:0] irqMask_q;
  logic       busy_q;
  key_state_t key_q;
  key_state_t key_d;

  // timed-access unlock: any other write with byte lane 0 selected closes the window
  logic keyOpen;
  logic protWr;

  assign keyOpen = key_q == KEY_OPEN;
  assign protWr  = busWr && keyOpen && (hitTrig || hitCtl);

  always_comb
  begin
    key_d = key_q;
    if (busWr)
    begin
      if (hitKey && wByte == `KEY_FIRST)
        key_d = KEY_HALF;
      else if (hitKey && wByte == `KEY_SECOND && key_q == KEY_HALF)
        key_d = KEY_OPEN;
      else
        key_d = KEY_IDLE;
    end
  end

  // command fields
  logic [1:0] tgt;
  logic       oeCtl;
  logic       ceCtl;
  logic [3:0] opc;

  assign tgt   = command_q[7:6];
  assign oeCtl = command_q[`CMD_OE_BIT];
  assign ceCtl = command_q[`CMD_CE_BIT];
  assign opc   = command_q[3:0];

  // operation decode
  logic isErase;
  logic isProg;
  logic isRead;
  logic isWriteOp;

  assign isErase   = oeCtl && !ceCtl && opc == `OPC_ERASE;
  assign isProg    = oeCtl && !ceCtl && opc == `OPC_PROG;
  assign isRead    = !oeCtl && !ceCtl && opc == `OPC_READ;
  assign isWriteOp = isErase || isProg;

  // config bytes live at 0, 2 and 3 only
  logic cfgAddrOk;
  logic cfgEraseOk;

  assign cfgAddrOk  = addrHigh_q == 8'h00
                    && (addrLow_q == 8'h00 || addrLow_q == 8'h02 || addrLow_q == 8'h03);
  assign cfgEraseOk = addrHigh_q == 8'h00;

  // access legality against the running code region
  logic tgtApp;
  logic tgtLdr;
  logic tgtCfg;
  logic illegal;

  assign tgtApp  = tgt == `TGT_APP;
  assign tgtLdr  = tgt == `TGT_LOADER;
  assign tgtCfg  = tgt == `TGT_CONFIG;
  assign illegal = codeExternal
                 || ((isWriteOp || isRead) && !tgtApp && !tgtLdr && !tgtCfg)
                 || (tgtApp && isWriteOp && !codeInLoader)
                 || (tgtLdr && isWriteOp && !codeInLoader && !loaderUpd_q)
                 || (tgtLdr && isWriteOp && codeInLoader)
                 || (tgtCfg && (isWriteOp || isRead) && !codeInLoader)
                 || (tgtCfg && isErase && !cfgEraseOk)
                 || (tgtCfg && (isProg || isRead) && !cfgAddrOk);

  // a launch is a protected one written to the go bit while idle and enabled
  logic goWr;
  logic launch;
  logic realOp;
  logic quickEnd;

  assign goWr     = protWr && hitTrig && wByte[`TRG_GO_BIT];
  assign launch   = goWr && !busy_q && progEn_q;
  assign realOp   = launch && !illegal && (isErase || isProg || isRead);
  assign quickEnd = launch && !realOp;

  // flash-side operation and address; page erase ignores the low byte
  flash_op_t  seqOp;
  logic [17:0] seqAddr;
  logic [7:0]  lowEff;

  assign seqOp   = isRead ? FL_READ
                 : isProg ? FL_PROG
                 : tgtCfg ? FL_ERASE_CFG : FL_ERASE;
  assign lowEff  = isErase ? 8'h00 : addrLow_q;
  assign seqAddr = {tgt, addrHigh_q, lowEff};

  logic [7:0] seqRdata;
  logic       seqFinished;

  isp_flash_sequencer u_seq (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .start      (realOp),
    .op         (seqOp),
    .addr       (seqAddr),
    .wdata      (data_q),
    .rdata      (seqRdata),
    .finished   (seqFinished),
    .flashReq   (flashReq),
    .flashOp    (flashOp),
    .flashAddr  (flashAddr),
    .flashWdata (flashWdata),
    .flashRdata (flashRdata),
    .flashDone  (flashDone)
  );

  // completion: real access ends on the sequencer, others one cycle after launch
  logic quickEnd_q;
  logic readPend_q;
  logic opEnd;
  logic faultSet;

  assign opEnd    = seqFinished || quickEnd_q;
  assign faultSet = launch && illegal;

  // read data for the bus
  logic [7:0] rdByte;
  logic [1:0] statNext;

  assign rdByte = hitAlo  ? addrLow_q
                : hitAhi  ? addrHigh_q
                : hitData ? data_q
                : hitCmd  ? command_q
                : hitCtl  ? {1'b0, fault_q, loaderUpd_q, 4'h0, progEn_q}
                : hitStat ? {6'h00, irqStat_q}
                : hitMask ? {6'h00, irqMask_q}
                : 8'h00; // trigger and key read zero

  // event bits; a set in the read cycle survives the clear
  logic [1:0] statEvt;
  assign statEvt  = {faultSet, opEnd};
  assign statNext = ((busRd && hitStat) ? 2'b00 : irqStat_q) | statEvt;

  // bus handshake; unmapped indices answer with zero data
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_q <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_q <= busReq;
      if (busRd)
        dat_o <= {24'h000000, hitAny ? rdByte : 8'h00};
    end
  end

  assign ack_o = ack_q;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      key_q <= KEY_IDLE;
    else
      key_q <= key_d;
  end

  // address and command registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addrLow_q  <= `RST_ADDR_LOW;
      addrHigh_q <= `RST_ADDR_HIGH;
      command_q  <= `RST_COMMAND;
    end
    else if (busWr)
    begin
      if (hitAlo)
        addrLow_q <= wByte;
      if (hitAhi)
        addrHigh_q <= wByte;
      if (hitCmd)
        command_q <= wByte;
    end
  end

  // data register: a finished read overrides a concurrent bus write
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      data_q <= `RST_DATA;
    else if (seqFinished && readPend_q)
      data_q <= seqRdata;
    else if (busWr && hitData)
      data_q <= wByte;
  end

  // chip control; hardware setting the fault wins over a software clear
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      progEn_q    <= 1'b0;
      loaderUpd_q <= 1'b0;
      fault_q     <= 1'b0;
    end
    else
    begin
      if (protWr && hitCtl)
      begin
        progEn_q    <= wByte[`CTL_EN_BIT];
        loaderUpd_q <= wByte[`CTL_LDU_BIT];
      end
      if (faultSet)
        fault_q <= 1'b1;
      else if (protWr && hitCtl)
        fault_q <= wByte[`CTL_FAULT_BIT];
    end
  end

  // operation tracking and cpu hold
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_q     <= 1'b0;
      quickEnd_q <= 1'b0;
      readPend_q <= 1'b0;
      cpuHold    <= 1'b0;
    end
    else
    begin
      quickEnd_q <= quickEnd;
      if (launch)
      begin
        busy_q     <= 1'b1;
        cpuHold    <= 1'b1;
        readPend_q <= realOp && isRead;
      end
      else if (opEnd)
      begin
        busy_q     <= 1'b0;
        cpuHold    <= 1'b0;
        readPend_q <= 1'b0;
      end
    end
  end

  // oscillator follows the enable bit
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      oscEnable <= 1'b0;
    else
      oscEnable <= progEn_q;
  end

  // interrupt status, mask and level output
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqStat_q <= 2'b00;
      irqMask_q <= 2'b00;
      irq       <= 1'b0;
    end
    else
    begin
      irqStat_q <= statNext;
      if (busWr && hitMask)
        irqMask_q <= wByte[1:0];
      irq <= |(statNext & ((busWr && hitMask) ? wByte[1:0] : irqMask_q));
    end
  end

endmodule

// ==== design/isp_flash_pkg.sv ====
package isp_flash_pkg;

  // access kinds presented to the flash array
  typedef enum logic [1:0] {FL_READ, FL_PROG, FL_ERASE, FL_ERASE_CFG} flash_op_t;

  // unlock progress of the timed-access key
  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} key_state_t;

  // flash access sequencer
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_REQ, SEQ_END} seq_state_t;

endpackage

// ==== design/isp_flash_regs.svh ====
// Behaviour
// - command register: address 17:16 in 7:6, oe bit 5, ce bit 4, opcode 3:0.
// - high address register gives bits 15:8 of every operation address.
// - low address register gives bits 7:0 and resets to zero.
// - a finished read leaves the fetched byte in the data register.
// - writing one to trigger bit 0 starts the selected operation.
// - while an operation runs the cpu program counter is held.
// - at completion the trigger clears itself and the cpu is released.
// - the trigger bit always reads as zero.
// - the trigger accepts writes only right after the timed-access unlock.
// - decode: erase 1/0/0010, program 1/0/0001, read 0/0/0000, standby 1/1.
// - target 00 application, 01 loader, 11 config bytes 0, 2 and 3.
// - config erase clears all config bytes; high address zero, low ignored.
// - page erase acts on a 256-byte page; address low byte is zero.
// - operations need the programming enable bit, which also starts the oscillator.
// - an illegal target for the running code sets a sticky fault flag.
`ifndef ISP_FLASH_REGS_SVH
`define ISP_FLASH_REGS_SVH

// register indices; byte address is four times the index
`define IDX_TRIGGER   8'ha4
`define IDX_ADDR_LOW  8'ha6
`define IDX_ADDR_HIGH 8'ha7
`define IDX_DATA      8'hae
`define IDX_COMMAND   8'haf
`define IDX_CHIP_CTL  8'h9f
`define IDX_KEY       8'hc7
`define IDX_IRQ_STAT  8'hb0
`define IDX_IRQ_MASK  8'hb1

// field positions
`define CMD_OE_BIT    5
`define CMD_CE_BIT    4
`define CTL_EN_BIT    0
`define CTL_LDU_BIT   5
`define CTL_FAULT_BIT 6
`define TRG_GO_BIT    0
`define IRQ_DONE_BIT  0
`define IRQ_FAULT_BIT 1

// operation codes and targets
`define OPC_ERASE     4'h2
`define OPC_PROG      4'h1
`define OPC_READ      4'h0
`define TGT_APP       2'h0
`define TGT_LOADER    2'h1
`define TGT_CONFIG    2'h3

// reset values
`define RST_ADDR_LOW  8'h00
`define RST_ADDR_HIGH 8'h00
`define RST_DATA      8'h00
`define RST_COMMAND   8'h30
`define RST_CHIP_CTL  8'h00

// unlock keys
`define KEY_FIRST     8'haa
`define KEY_SECOND    8'h55

`endif

// ==== design/isp_flash_sequencer.sv ====
`timescale 1ns/1ps
module isp_flash_sequencer
  import isp_flash_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  // launch side
  input  wire logic                     start,
  input  wire isp_flash_pkg::flash_op_t op,
  input  wire logic [17:0]              addr,
  input  wire logic [7:0]               wdata,
  output logic [7:0]                    rdata,
  output logic                          finished,
  // flash array side
  output logic                          flashReq,
  output isp_flash_pkg::flash_op_t      flashOp,
  output logic [17:0]                   flashAddr,
  output logic [7:0]                    flashWdata,
  input  wire logic [7:0]               flashRdata,
  input  wire logic                     flashDone
);

  seq_state_t state_q;
  seq_state_t state_d;

  // request held until the array reports done; cell timing is the array's job
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SEQ_IDLE: if (start) state_d = SEQ_REQ;
      SEQ_REQ:  if (flashDone) state_d = SEQ_END;
      SEQ_END:  state_d = SEQ_IDLE;
      default:  state_d = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q    <= SEQ_IDLE;
      flashReq   <= 1'b0;
      flashOp    <= FL_READ;
      flashAddr  <= 18'h00000;
      flashWdata <= 8'h00;
      rdata      <= 8'h00;
      finished   <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      finished <= (state_q == SEQ_REQ) && flashDone;
      if (state_q == SEQ_IDLE && start)
      begin
        flashReq   <= 1'b1;
        flashOp    <= op;
        flashAddr  <= addr;
        flashWdata <= wdata;
      end
      else if (state_q == SEQ_REQ && flashDone)
      begin
        flashReq <= 1'b0;
        rdata    <= flashRdata; // captured for reads, harmless otherwise
      end
    end
  end

endmodule

// ==== verif/flash_array_model.sv ====
`timescale 1ns/1ps
module flash_array_model
  import isp_flash_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  // request from the engine
  input  wire logic                     flashReq,
  input  wire isp_flash_pkg::flash_op_t flashOp,
  input  wire logic [17:0]              flashAddr,
  input  wire logic [7:0]               flashWdata,
  input  wire logic [3:0]               flashDelay,
  // answer
  output logic [7:0]                    flashRdata,
  output logic                          flashDone
);
  logic [7:0]  mem [logic [17:0]];
  logic [3:0]  waitCnt;
  logic [17:0] lastAddr;
  flash_op_t   lastOp;
  int          opCount = 0;
  // read data toggles outside the answer cycle so stale values never match
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flashDone <= 1'b0;
      waitCnt <= 4'h0;
      flashRdata <= 8'h00;
    end
    else if (flashReq && !flashDone && waitCnt < flashDelay)
    begin
      waitCnt <= waitCnt + 4'h1;
      flashRdata <= ~flashRdata;
    end
    else if (flashReq && !flashDone)
    begin
      flashDone <= 1'b1;
      waitCnt <= 4'h0;
      opCount <= opCount + 1;
      lastAddr <= flashAddr;
      lastOp <= flashOp;
      flashRdata <= mem.exists(flashAddr) ? mem[flashAddr] : 8'hff;
      if (flashOp == FL_PROG)
        mem[flashAddr] = flashWdata;
      // whole 256-byte page goes back to the blank value
      if (flashOp == FL_ERASE)
        for (int i = 0; i < 256; i++) mem.delete({flashAddr[17:8], 8'(i)});
      if (flashOp == FL_ERASE_CFG)
        for (int i = 0; i < 4; i++) mem.delete({16'h c000, 2'(i)});
    end
    else
    begin
      flashDone <= 1'b0;
      flashRdata <= ~flashRdata;
    end
  end
endmodule

// ==== verif/isp_flash_command_unit_assertions.sv ====
`timescale 1ns/1ps
module isp_flash_command_unit_assertions
  import isp_flash_pkg::*;
#(
  parameter int ADDR_W = 10
)
(
  // bus side
  input wire logic                     clk_sys,
  input wire logic                     arst_n,
  input wire logic                     cyc_i,
  input wire logic                     stb_i,
  input wire logic                     we_i,
  input wire logic [ADDR_W-1:0]        adr_i,
  input wire logic [31:0]              dat_o,
  input wire logic                     ack_o,
  // engine side
  input wire logic                     cpuHold,
  input wire logic                     flashReq,
  input wire isp_flash_pkg::flash_op_t flashOp,
  input wire logic [17:0]              flashAddr,
  input wire logic [7:0]               flashWdata,
  input wire logic                     flashDone
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // array answered while the request still stood
  sequence doneSeen;
    flashReq && flashDone;
  endsequence
  // trigger read answered in this cycle
  sequence trigRead;
    ack_o && $past(!we_i && adr_i[9:2] == 8'ha4);
  endsequence
  ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not acked in one cycle");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  trig_zero_a: assert property (trigRead |-> dat_o == 32'h0)
    else $error("trigger read not zero");
  hold_busy_a: assert property (flashReq |-> cpuHold)
    else $error("flash busy without cpu hold");
  req_release_a: assert property (doneSeen |=> !flashReq)
    else $error("request kept after done");
  hold_release_a: assert property (doneSeen |-> ##[1:2] !cpuHold)
    else $error("cpu not released after done");
  addr_stable_a: assert property (flashReq && !flashDone |=>
    $stable(flashAddr) && $stable(flashOp) && $stable(flashWdata))
    else $error("request changed while waiting");
  erase_align_a: assert property (flashReq && flashOp == FL_ERASE |->
    flashAddr[7:0] == 8'h00)
    else $error("page erase not page aligned");
  cfg_erase_a: assert property (flashReq && flashOp == FL_ERASE_CFG |->
    flashAddr[17:8] == 10'h300)
    else $error("config erase with bad address");
  cfg_addr_a: assert property (flashReq && flashAddr[17:16] == 2'h3 && !flashOp[1] |->
    flashAddr[15:0] inside {16'h0000, 16'h0002, 16'h0003})
    else $error("config access at bad address");
  no_tgt2_a: assert property (flashReq |-> flashAddr[17:16] != 2'h2)
    else $error("request to undefined target");
endmodule

bind isp_flash_command_unit isp_flash_command_unit_assertions #(.ADDR_W(ADDR_W)) chk_i (
  .clk_sys(clk_sys), .arst_n(arst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .cpuHold(cpuHold), .flashReq(flashReq),
  .flashOp(flashOp), .flashAddr(flashAddr), .flashWdata(flashWdata), .flashDone(flashDone));

// ==== verif/isp_flash_command_unit_tb.sv ====
`timescale 1ns/1ps
`include "isp_flash_regs.svh"
module isp_flash_command_unit_tb;
  import isp_flash_pkg::*;
  logic        clk_sys, arst_n, cyc_i, stb_i, we_i, ack_o;
  logic [9:0]  adr_i;
  logic [3:0]  sel_i, flashDelay;
  logic [31:0] dat_i, dat_o;
  logic        codeInLoader, codeExternal, cpuHold, flashReq, flashDone, oscEnable, irq;
  flash_op_t   flashOp;
  logic [17:0] flashAddr;
  logic [7:0]  flashWdata, flashRdata;
  int          failures, samples_checked, cycles;

  isp_flash_command_unit isp_flash_command_unit_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .codeInLoader(codeInLoader), .codeExternal(codeExternal), .cpuHold(cpuHold),
    .flashReq(flashReq), .flashOp(flashOp), .flashAddr(flashAddr),
    .flashWdata(flashWdata), .flashRdata(flashRdata), .flashDone(flashDone),
    .oscEnable(oscEnable), .irq(irq));
  flash_array_model flash_array_model_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .flashReq(flashReq), .flashOp(flashOp),
    .flashAddr(flashAddr), .flashWdata(flashWdata), .flashDelay(flashDelay),
    .flashRdata(flashRdata), .flashDone(flashDone));

  // clock and hang guard
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; ack and read data taken at the same edge
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    output logic [7:0] r);
    int n;
    @(posedge clk_sys);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    n = 0;
    do begin @(posedge clk_sys); n++; end while (ack_o !== 1'b1 && n < 50);
    if (n == 50) failures++;
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, idx, d, r);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    wb(1'b0, idx, 8'h00, r);
    chk($sformatf("reg %h", idx), 32'(r), 32'(exp));
  endtask

  // unlock keys just before the protected write
  task automatic prot(input logic [7:0] idx, input logic [7:0] d);
    wr(`IDX_KEY, `KEY_FIRST);
    wr(`IDX_KEY, `KEY_SECOND);
    wr(idx, d);
  endtask

  // set up, fire, wait for release, then check the event and its interrupt
  task automatic op(input logic [7:0] c, h, l, input int ops, input logic [7:0] st,
                    input logic ir);
    int n0;
    int k;
    n0 = flash_array_model_i.opCount;
    wr(`IDX_COMMAND, c);
    wr(`IDX_ADDR_HIGH, h);
    wr(`IDX_ADDR_LOW, l);
    prot(`IDX_TRIGGER, 8'h01);
    k = 0;
    while (cpuHold !== 1'b0 && k < 100) begin @(posedge clk_sys); k++; end
    if (k == 100) failures++;
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'(irq), 32'(ir));
    chk("flash ops", 32'(flash_array_model_i.opCount - n0), 32'(ops));
    rd(`IDX_IRQ_STAT, st);
    @(posedge clk_sys);
    chk("irq cleared", 32'(irq), 32'h0);
  endtask

  initial
  begin
    clk_sys = 0; arst_n = 0; cyc_i = 0; stb_i = 0; we_i = 0; adr_i = 0; sel_i = 4'hf;
    dat_i = 0; codeInLoader = 1; codeExternal = 0; flashDelay = 0;
    failures = 0; samples_checked = 0; cycles = 0;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(`IDX_ADDR_LOW, `RST_ADDR_LOW);
    rd(`IDX_DATA, `RST_DATA);
    rd(`IDX_COMMAND, `RST_COMMAND);
    rd(`IDX_TRIGGER, 8'h00);
    rd(8'h10, 8'h00);
    wr(`IDX_COMMAND, 8'hc5);
    rd(`IDX_COMMAND, 8'hc5);
    wr(`IDX_ADDR_HIGH, 8'h5a);
    rd(`IDX_ADDR_HIGH, 8'h5a);
    sel_i <= 4'he;
    wr(`IDX_ADDR_HIGH, 8'h11);
    sel_i <= 4'hf;
    rd(`IDX_ADDR_HIGH, 8'h5a);
    wr(`IDX_IRQ_MASK, 8'h03);
    // no programming enable yet: trigger is ignored
    op(8'h21, 8'h01, 8'h23, 0, 8'h00, 1'b0);
    prot(`IDX_CHIP_CTL, 8'h01);
    @(posedge clk_sys);
    chk("osc", 32'(oscEnable), 32'h1);
    wr(`IDX_TRIGGER, 8'h01);
    @(posedge clk_sys);
    chk("unprotected go", 32'(cpuHold), 32'h0);
    wr(`IDX_DATA, 8'h5c);
    op(8'h21, 8'h01, 8'h23, 1, 8'h01, 1'b1);
    chk("addr", 32'(flash_array_model_i.lastAddr), 32'h00123);
    flashDelay <= 4'h7;
    op(8'h00, 8'h01, 8'h23, 1, 8'h01, 1'b1);
    rd(`IDX_DATA, 8'h5c);
    rd(`IDX_TRIGGER, 8'h00);
    op(8'h22, 8'h01, 8'h00, 1, 8'h01, 1'b1);
    chk("erase op", 32'(flash_array_model_i.lastOp), 32'(FL_ERASE));
    op(8'h00, 8'h01, 8'h23, 1, 8'h01, 1'b1);
    rd(`IDX_DATA, 8'hff);
    op(8'h31, 8'h01, 8'h23, 0, 8'h01, 1'b1);
    // application code may not program its own area or the loader, nor read config
    codeInLoader <= 1'b0;
    op(8'h21, 8'h00, 8'h00, 0, 8'h03, 1'b1);
    op(8'h61, 8'h00, 8'h00, 0, 8'h03, 1'b1);
    op(8'hc0, 8'h00, 8'h00, 0, 8'h03, 1'b1);
    rd(`IDX_CHIP_CTL, 8'h41);
    prot(`IDX_CHIP_CTL, 8'h01);
    rd(`IDX_CHIP_CTL, 8'h01);
    // loader update enable lets application code program the loader area
    prot(`IDX_CHIP_CTL, 8'h21);
    op(8'h61, 8'h00, 8'h10, 1, 8'h01, 1'b1);
    // standby ignores the target bits, so no fault even for config
    op(8'hf0, 8'h00, 8'h00, 0, 8'h01, 1'b1);
    codeInLoader <= 1'b1;
    op(8'he2, 8'h00, 8'h55, 1, 8'h01, 1'b1);
    chk("cfg erase", 32'(flash_array_model_i.lastOp), 32'(FL_ERASE_CFG));
    chk("cfg erase addr", 32'(flash_array_model_i.lastAddr), 32'h30000);
    op(8'he1, 8'h00, 8'h02, 1, 8'h01, 1'b1);
    op(8'he1, 8'h00, 8'h01, 0, 8'h03, 1'b1);
    codeExternal <= 1'b1;
    op(8'h21, 8'h00, 8'h00, 0, 8'h03, 1'b1);
    codeExternal <= 1'b0;
    // done masked out keeps the line low
    wr(`IDX_IRQ_MASK, 8'h02);
    op(8'h31, 8'h00, 8'h00, 0, 8'h01, 1'b0);
    rd(`IDX_KEY, 8'h00);
    give_verdict();
  end
endmodule
